//--- core/dbpc_defs.vh
`ifndef DBPC_DEFS_VH
`define DBPC_DEFS_VH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define DBPC_ADDR_CTRL0      8'h00
`define DBPC_ADDR_CTRL1      8'h04
`define DBPC_ADDR_CTRL2      8'h08
`define DBPC_ADDR_STATUS     8'h0c
`define DBPC_ADDR_DATA_BASE  8'h40
`define DBPC_ADDR_DATA_LAST  8'h7c

// ------------------------------------------------------------
// Control 0 fields
// ------------------------------------------------------------
`define DBPC_C0_EN           7
`define DBPC_C0_REFSEL       6
`define DBPC_C0_TRGSEL       5
`define DBPC_C0_STRG         4
`define DBPC_C0_LP           3
`define DBPC_C0_WIE          2
`define DBPC_C0_TIE          1
`define DBPC_C0_BIE          0

// ------------------------------------------------------------
// Control 1 fields
// ------------------------------------------------------------
`define DBPC_C1_WM_HI        4
`define DBPC_C1_WM_LO        3
`define DBPC_C1_MD_HI        2
`define DBPC_C1_MD_LO        1
`define DBPC_C1_BFE          0

// ------------------------------------------------------------
// Control 2 fields
// ------------------------------------------------------------
`define DBPC_C2_RP_HI        7
`define DBPC_C2_RP_LO        4
`define DBPC_C2_UP_HI        3
`define DBPC_C2_UP_LO        0

// ------------------------------------------------------------
// Status fields
// ------------------------------------------------------------
`define DBPC_ST_WM           2
`define DBPC_ST_TOP          1
`define DBPC_ST_BOT          0

// ------------------------------------------------------------
// Modes and reset values
// ------------------------------------------------------------
`define DBPC_MODE_NORMAL     2'h0
`define DBPC_MODE_SWING      2'h1
`define DBPC_MODE_SCAN       2'h2
`define DBPC_RST_CTRL0       8'h00
`define DBPC_RST_CTRL1       5'h00
`define DBPC_RST_UPPER       4'hf
`define DBPC_RST_STATUS      3'h2
`define DBPC_DATA_HI_LSB     8

`endif

//--- core/dbpc_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "dbpc_defs.vh"

// Operation
// - Control0 bit7 enables whole converter
// - Control0 bit6 selects external reference
// - Control0 bit5 selects software trigger
// - Soft trigger write-only, advances once
// - Control0 bit3 requests low power
// - Control0 bits2..0 enable three interrupts
// - Watermark flag at distance one to four
// - Control1 bits2:1 select buffer mode
// - Buffer disabled uses first word
// - Control2 high nibble is read pointer
// - Upper limit nibble caps pointer
// - Enabled converter advances on triggers only with buffer enabled
// - Mode change keeps pointer value
// - Normal mode wraps to zero
// - Swing mode descends after upper limit
// - Scan mode stops at upper limit
// - Reset gives disabled default configuration
// - Operation continues in wait, debug
// - Flags clear on zero write only
// - Top means zero, bottom means limit
module dbpc_ctrl #(
  parameter DEPTH  = 16,
  parameter PTR_W  = 4,
  parameter DATA_W = 12
) (
  // Clock, reset, enable
  input  wire              ref_clk_in,
  input  wire              rst_n_in,
  input  wire              clk_en_in,
  // APB slave
  input  wire              psel_in,
  input  wire              penable_in,
  input  wire              pwrite_in,
  input  wire [7:0]        paddr_in,
  input  wire [31:0]       pwdata_in,
  output reg  [31:0]       prdata_out,
  output reg               pready_out,
  output reg               pslverr_out,
  // Hardware trigger pulse
  input  wire              hw_trigger_in,
  // Analog core controls
  output reg               converter_enable_out,
  output reg               reference_select_out,
  output reg               low_power_select_out,
  output reg  [DATA_W-1:0] code_out,
  output reg               irq_out
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg [7:0]        ctrl0_q;
  reg [4:0]        ctrl1_q;
  reg [PTR_W-1:0]  read_pointer_q;
  reg [PTR_W-1:0]  upper_limit_q;
  reg              swing_down_q;
  reg [2:0]        status_q;
  reg [DATA_W-1:0] mem_q [0:DEPTH-1];
  reg [3:0]        hi_hold_q;
  reg              hi_pend_q;
  reg [PTR_W-1:0]  next_ptr_d;
  reg              next_dn_d;
  reg [2:0]        status_d;
  reg [31:0]       rdata_d;

  wire             wr_acc;
  wire             rd_acc;
  wire             data_hit;
  wire [PTR_W-1:0] data_idx;
  wire             soft_trg;
  wire             hw_trg;
  wire             trigger;
  wire [1:0]       mode;
  wire [PTR_W:0]   distance;
  wire [PTR_W:0]   wm_words;
  wire             ptr_wr;
  wire [PTR_W-1:0] ptr_wr_val;
  wire [PTR_W-1:0] ptr_new;
  wire             top_now;
  wire             bot_now;
  wire             wm_now;
  reg              top_was_q;
  reg              bot_was_q;
  reg              wm_was_q;

  wire             wr_c0;
  wire             wr_c1;
  wire             wr_c2;
  wire             wr_st;
  wire             mapped;
  wire [PTR_W-1:0] limit_eff;
  wire [2:0]       cond_now;
  wire [2:0]       cond_was;
  wire [2:0]       flag_set;
  wire [DATA_W-1:0] code_sel;
  wire             irq_d;

  assign wr_acc   = psel_in & penable_in & pwrite_in & clk_en_in;
  assign rd_acc   = psel_in & ~penable_in & ~pwrite_in;
  assign data_hit = (paddr_in >= `DBPC_ADDR_DATA_BASE) && (paddr_in <= `DBPC_ADDR_DATA_LAST)
                    && (paddr_in[1:0] == 2'h0);
  assign data_idx = paddr_in[PTR_W+1:2];
  assign mode     = ctrl1_q[`DBPC_C1_MD_HI:`DBPC_C1_MD_LO];

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function reg_known;
    input [7:0] addr;
    begin
      reg_known = (addr == `DBPC_ADDR_CTRL0) || (addr == `DBPC_ADDR_CTRL1)
                  || (addr == `DBPC_ADDR_CTRL2) || (addr == `DBPC_ADDR_STATUS)
                  || ((addr >= `DBPC_ADDR_DATA_BASE) && (addr <= `DBPC_ADDR_DATA_LAST)
                      && (addr[1:0] == 2'h0));
    end
  endfunction

  assign mapped = reg_known(paddr_in);

  // Write strobes, one per control or status register; data words use wr_acc and data_hit
  assign wr_c0  = wr_acc && mapped && (paddr_in == `DBPC_ADDR_CTRL0);
  assign wr_c1  = wr_acc && mapped && (paddr_in == `DBPC_ADDR_CTRL1);
  assign wr_c2  = wr_acc && mapped && (paddr_in == `DBPC_ADDR_CTRL2);
  assign wr_st  = wr_acc && mapped && (paddr_in == `DBPC_ADDR_STATUS);

  // ------------------------------------------------------------
  // Trigger selection
  // ------------------------------------------------------------
  // soft trigger pulse
  assign soft_trg = wr_c0 && pwdata_in[`DBPC_C0_STRG]
                    && pwdata_in[`DBPC_C0_TRGSEL] && pwdata_in[`DBPC_C0_EN] && ctrl1_q[`DBPC_C1_BFE];
  assign hw_trg   = hw_trigger_in & ~ctrl0_q[`DBPC_C0_TRGSEL];
  assign trigger  = clk_en_in & ctrl0_q[`DBPC_C0_EN] & ctrl1_q[`DBPC_C1_BFE] & (soft_trg | hw_trg);

  // ------------------------------------------------------------
  // Pointer stepping
  // ------------------------------------------------------------
  always @* begin
    next_ptr_d = read_pointer_q;
    next_dn_d  = swing_down_q;
    case (mode)
      `DBPC_MODE_NORMAL: begin
        next_ptr_d = (read_pointer_q >= upper_limit_q) ? {PTR_W{1'b0}} : read_pointer_q + 1'b1;
      end
      `DBPC_MODE_SWING: begin
        if (read_pointer_q >= upper_limit_q && upper_limit_q != {PTR_W{1'b0}}) begin
          next_ptr_d = upper_limit_q - 1'b1;
          next_dn_d  = 1'b1;
        end else if (read_pointer_q == {PTR_W{1'b0}}) begin
          next_ptr_d = (upper_limit_q == {PTR_W{1'b0}}) ? {PTR_W{1'b0}} : {{(PTR_W-1){1'b0}}, 1'b1};
          next_dn_d  = 1'b0;
        end else if (swing_down_q) begin
          next_ptr_d = read_pointer_q - 1'b1;
        end else begin
          next_ptr_d = read_pointer_q + 1'b1;
        end
      end
      `DBPC_MODE_SCAN: begin
        if (read_pointer_q < upper_limit_q) begin
          next_ptr_d = read_pointer_q + 1'b1;
        end
      end
      default: begin
        next_ptr_d = read_pointer_q;
      end
    endcase
  end

  assign ptr_wr     = wr_c2;
  assign ptr_wr_val = (pwdata_in[`DBPC_C2_RP_HI:`DBPC_C2_RP_LO] > pwdata_in[`DBPC_C2_UP_HI:`DBPC_C2_UP_LO]) ?
                      pwdata_in[`DBPC_C2_UP_HI:`DBPC_C2_UP_LO] : pwdata_in[`DBPC_C2_RP_HI:`DBPC_C2_RP_LO];
  assign ptr_new    = ptr_wr ? ptr_wr_val : (trigger ? next_ptr_d : read_pointer_q);

  // ------------------------------------------------------------
  // Status conditions
  // ------------------------------------------------------------
  // top and bottom
  assign top_now  = (ptr_new == {PTR_W{1'b0}});
  // Limit in force after this edge
  assign limit_eff = ptr_wr ? pwdata_in[`DBPC_C2_UP_HI:`DBPC_C2_UP_LO] : upper_limit_q;
  assign bot_now  = (ptr_new == limit_eff);
  assign distance = {1'b0, limit_eff} - {1'b0, ptr_new};
  assign wm_words = {{(PTR_W-1){1'b0}}, ctrl1_q[`DBPC_C1_WM_HI:`DBPC_C1_WM_LO]} + 1'b1;
  assign wm_now   = (distance == wm_words);

  assign cond_now = {wm_now, top_now, bot_now};
  assign cond_was = {wm_was_q, top_was_q, bot_was_q};

  genvar gi;
  generate
    for (gi = 0; gi <= `DBPC_ST_WM; gi = gi + 1) begin : g_flag
      // Rising condition sets its flag
      assign flag_set[gi] = clk_en_in & cond_now[gi] & ~cond_was[gi];
    end
  endgenerate

  always @* begin
    status_d = status_q;
    if (wr_st) begin
      status_d = status_q & pwdata_in[2:0];
    end
    // A set in the clearing cycle wins
    status_d = status_d | flag_set;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // disabled defaults
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl0_q        <= `DBPC_RST_CTRL0;
      ctrl1_q        <= `DBPC_RST_CTRL1;
      read_pointer_q <= {PTR_W{1'b0}};
      upper_limit_q  <= `DBPC_RST_UPPER;
      swing_down_q   <= 1'b0;
      status_q       <= `DBPC_RST_STATUS;
      top_was_q      <= 1'b1;
      bot_was_q      <= 1'b0;
      wm_was_q       <= 1'b0;
      hi_hold_q      <= 4'h0;
      hi_pend_q      <= 1'b0;
    end else if (clk_en_in) begin
      if (wr_c0) begin
        ctrl0_q <= pwdata_in[7:0] & ~(8'h01 << `DBPC_C0_STRG);
      end
      if (wr_c1) begin
        ctrl1_q <= pwdata_in[4:0];
      end
      if (ptr_wr) begin
        upper_limit_q <= pwdata_in[`DBPC_C2_UP_HI:`DBPC_C2_UP_LO];
        swing_down_q  <= 1'b0;
      end else if (trigger) begin
        swing_down_q <= next_dn_d;
      end
      read_pointer_q <= ptr_new;
      status_q       <= status_d;
      top_was_q      <= top_now;
      bot_was_q      <= bot_now;
      wm_was_q       <= wm_now;
      if (wr_acc && data_hit) begin
        hi_hold_q <= pwdata_in[DATA_W-1:`DBPC_DATA_HI_LSB];
        hi_pend_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Data buffer
  // ------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (clk_en_in && wr_acc && data_hit) begin
      mem_q[data_idx] <= pwdata_in[DATA_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always @* begin
    rdata_d = 32'h0000_0000;
    if (data_hit) begin
      rdata_d[DATA_W-1:0] = mem_q[data_idx];
    end else begin
      case (paddr_in)
        `DBPC_ADDR_CTRL0:  rdata_d[7:0] = ctrl0_q;
        `DBPC_ADDR_CTRL1:  rdata_d[4:0] = ctrl1_q;
        `DBPC_ADDR_CTRL2:  rdata_d[7:0] = {read_pointer_q, upper_limit_q};
        `DBPC_ADDR_STATUS: rdata_d[2:0] = status_q;
        default:           rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Analog side selections
  // ------------------------------------------------------------
  // first word when buffer off
  assign code_sel = ctrl1_q[`DBPC_C1_BFE] ? mem_q[read_pointer_q] : mem_q[0];
  assign irq_d    = (status_q[`DBPC_ST_WM]  & ctrl0_q[`DBPC_C0_WIE])
                  | (status_q[`DBPC_ST_TOP] & ctrl0_q[`DBPC_C0_TIE])
                  | (status_q[`DBPC_ST_BOT] & ctrl0_q[`DBPC_C0_BIE]);

  // ------------------------------------------------------------
  // Bus answer
  // ------------------------------------------------------------
  // Zero wait states: ready follows every setup phase
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else if (clk_en_in) begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~mapped;
      if (rd_acc) begin
        prdata_out <= rdata_d;
      end
    end
  end

  // ------------------------------------------------------------
  // Analog core outputs
  // ------------------------------------------------------------
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      converter_enable_out <= 1'b0;
      reference_select_out <= 1'b0;
      low_power_select_out <= 1'b0;
      code_out             <= {DATA_W{1'b0}};
      irq_out              <= 1'b0;
    end else if (clk_en_in) begin
      converter_enable_out <= ctrl0_q[`DBPC_C0_EN];
      reference_select_out <= ctrl0_q[`DBPC_C0_REFSEL];
      low_power_select_out <= ctrl0_q[`DBPC_C0_LP];
      // Disabled converter drives code zero
      code_out             <= ctrl0_q[`DBPC_C0_EN] ? code_sel : {DATA_W{1'b0}};
      irq_out              <= irq_d;
    end
  end

endmodule // dbpc_ctrl

`default_nettype wire

//--- tb/dbpc_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbpc_defs.vh"
module dbpc_chk #(
  parameter DATA_W = 12
) (
  input wire logic              ref_clk_in,
  input wire logic              rst_n_in,
  input wire logic              clk_en_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [7:0]        paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic [31:0]       prdata_out,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  input wire logic              hw_trigger_in,
  input wire logic              converter_enable_out,
  input wire logic              reference_select_out,
  input wire logic              low_power_select_out,
  input wire logic [DATA_W-1:0] code_out,
  input wire logic              irq_out
);
  wire acc = psel_in && penable_in && clk_en_in;
  wire rd0 = acc && !pwrite_in && pready_out && paddr_in == `DBPC_ADDR_CTRL0;
  wire rd2 = acc && !pwrite_in && pready_out && paddr_in == `DBPC_ADDR_CTRL2;
  wire wr0 = acc && pwrite_in && paddr_in == `DBPC_ADDR_CTRL0;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  enable_wr_a: assert property (wr0 |-> ##2 converter_enable_out == $past(pwdata_in[7], 2))
    else $error("bad enable");
  refsel_wr_a: assert property (wr0 |-> ##2 reference_select_out == $past(pwdata_in[6], 2))
    else $error("bad reference select");
  lowpow_wr_a: assert property (wr0 |-> ##2 low_power_select_out == $past(pwdata_in[3], 2))
    else $error("bad power select");
  strg_read_a: assert property (rd0 |-> !prdata_out[`DBPC_C0_STRG])
    else $error("soft trigger bit reads one");
  ptr_limit_a: assert property (rd2 |-> prdata_out[7:4] <= prdata_out[3:0])
    else $error("pointer above limit");
  irq_mask_a: assert property (wr0 && pwdata_in[2:0] == 3'h0 |-> ##2 !irq_out)
    else $error("masked irq high");
  code_off_a: assert property (!converter_enable_out && !$past(converter_enable_out) |-> code_out == '0)
    else $error("code while disabled");
  reset_def_a: assert property ($rose(rst_n_in) |-> !converter_enable_out && !irq_out && !low_power_select_out)
    else $error("bad reset state");
endmodule // dbpc_chk
bind dbpc_ctrl dbpc_chk #(.DATA_W(DATA_W)) i_dbpc_chk (.ref_clk_in, .rst_n_in, .clk_en_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .hw_trigger_in,
  .converter_enable_out, .reference_select_out, .low_power_select_out, .code_out, .irq_out);
`default_nettype wire

//--- tb/dbpc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbpc_defs.vh"
module dbpc_ctrl_tb;
  logic        clk, rst_n, psel, pen, pwr, hw, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, r, c0;
  wire  [31:0] prdata;
  wire         pready, perr, en_o, ref_o, lp_o, irq;
  wire  [11:0] code;
  int          err_total, check_count, i, j, m, p, lim, wm, up;
  logic [2:0]  fl, cp, cn;
  logic [11:0] mem [16];

  dbpc_ctrl i_dbpc_ctrl (
    .ref_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(perr), .hw_trigger_in(hw), .converter_enable_out(en_o), .reference_select_out(ref_o),
    .low_power_select_out(lp_o), .code_out(code), .irq_out(irq));

  task automatic end_sim;
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      err_total++;
      end_sim;
    end
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // Soft write then hardware pulse; only the selected one moves
  task automatic trig(input int sw);
    apb(1'b1, `DBPC_ADDR_CTRL0, c0 | (sw ? 32'h30 : 32'h10));
    hw <= 1'b1;
    @(posedge clk);
    hw <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {rst_n, psel, pen, pwr, hw, paddr, pwdata} = '0;
    err_total = 0;
    check_count = 0;
    void'($urandom(32'h4549));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(r, i == 2 ? 32'hf : i == 3 ? 32'h2 : 32'h0);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    // whole words, high part written with low
    for (i = 0; i < 16; i++) begin
      mem[i] = 12'($urandom);
      apb(1'b1, 8'(`DBPC_ADDR_DATA_BASE + 4 * i), 32'(mem[i]));
    end
    for (m = 0; m < 4; m++) begin
      lim = 4 + $urandom % 6;
      wm = $urandom % 4;
      p = $urandom % (lim + 1);
      up = 1;
      c0 = 32'h80 | ($urandom & 32'h4f);
      apb(1'b1, `DBPC_ADDR_CTRL0, c0);
      apb(1'b1, `DBPC_ADDR_CTRL1, 32'(wm * 8 + m * 2 + 1));
      chk({en_o, ref_o, lp_o}, {1'b1, c0[6], c0[3]});
      apb(1'b1, `DBPC_ADDR_CTRL2, 32'(p * 16 + lim));
      apb(1'b1, `DBPC_ADDR_STATUS, 32'h0);
      fl = 3'h0;
      cp = {lim - p == wm + 1, p == 0, p == lim};
      for (j = 0; j < 2 * lim + 2; j++) begin
        trig(j % 2);
        case (m)
          0: p = (p == lim) ? 0 : p + 1;
          1: begin
            if (p == lim) up = 0;
            else if (p == 0) up = 1;
            p = up ? p + 1 : p - 1;
          end
          2: p = (p == lim) ? p : p + 1;
          default: ;
        endcase
        cn = {lim - p == wm + 1, p == 0, p == lim};
        fl = fl | (cn & ~cp);
        cp = cn;
        apb(1'b0, `DBPC_ADDR_CTRL2, 32'h0);
        chk(r, 32'(p * 16 + lim));
        chk(32'(code), 32'(mem[p]));
        apb(1'b0, `DBPC_ADDR_STATUS, 32'h0);
        chk(r, 32'(fl));
        chk(32'(irq), 32'(|(fl & c0[2:0])));
      end
      apb(1'b1, `DBPC_ADDR_STATUS, 32'h7);
      apb(1'b0, `DBPC_ADDR_STATUS, 32'h0);
      chk(r, 32'(fl));
      apb(1'b1, `DBPC_ADDR_CTRL1, 32'(((m + 1) % 4) * 2));
      apb(1'b0, `DBPC_ADDR_CTRL2, 32'h0);
      chk(r, 32'(p * 16 + lim));
      chk(32'(code), 32'(mem[0]));
    end
    apb(1'b1, `DBPC_ADDR_CTRL0, 32'h0);
    apb(1'b0, `DBPC_ADDR_CTRL0, 32'h0);
    chk({en_o, code}, 13'h0);
    end_sim;
  end
endmodule // dbpc_ctrl_tb
`default_nettype wire
